//--- common/ppcr_pkg.sv
// constants for the panel power configuration register bank
package ppcr_pkg;

  localparam int          DATA_W          = 8;
  localparam int          ADDR_W          = 8;

  // register addresses on command page 4
  localparam logic [7:0]  ADDR_EXT_CAP    = 8'h7A;
  localparam logic [7:0]  ADDR_LV_SENS    = 8'h87;
  localparam logic [7:0]  ADDR_LV_RESP    = 8'h88;
  localparam logic [7:0]  ADDR_VCOM_MODE  = 8'h8B;
  localparam logic [7:0]  ADDR_VGL_CLAMP  = 8'h8D;
  localparam logic [7:0]  ADDR_GMA_RELOAD = 8'hB2;

  // reset values, identical for power-on, software and hardware reset
  localparam logic [7:0]  RST_EXT_CAP     = 8'h00;
  localparam logic [7:0]  RST_LV_SENS     = 8'hBA;
  localparam logic [7:0]  RST_LV_RESP     = 8'h8B;
  localparam logic [7:0]  RST_VCOM_MODE   = 8'hE3;
  localparam logic [7:0]  RST_VGL_CLAMP   = 8'h14;
  localparam logic [7:0]  RST_GMA_RELOAD  = 8'hD1;

  // field positions
  localparam int          EXT_CAP_BIT     = 4;
  localparam int          SENS_MSB        = 7;
  localparam int          SENS_LSB        = 4;
  localparam int          RESP_BIT        = 7;
  localparam int          VCOM_ZERO_BIT   = 3;
  localparam int          CLAMP_MSB       = 6;
  localparam int          RELOAD_ON_BIT   = 7;
  localparam int          RELOAD_PER_BIT  = 6;

  // sensitivity codes
  localparam logic [3:0]  SENS_HIGH       = 4'hF;
  localparam logic [3:0]  SENS_MEDIUM     = 4'hB;
  localparam logic [3:0]  SENS_LOW        = 4'h2;
  localparam logic [3:0]  SENS_OFF        = 4'h0;

  // sensitivity level encoding on the analog control output
  localparam logic [1:0]  LEVEL_NONE      = 2'h0;
  localparam logic [1:0]  LEVEL_LOW       = 2'h1;
  localparam logic [1:0]  LEVEL_MEDIUM    = 2'h2;
  localparam logic [1:0]  LEVEL_HIGH      = 2'h3;

  // valid clamp code range, 0.18 V per step
  localparam logic [6:0]  CLAMP_MIN       = 7'h03;
  localparam logic [6:0]  CLAMP_MAX       = 7'h41;

  // periodic gamma reload spacing in display lines
  localparam int          RELOAD_LINES    = 8;

  localparam int          VCOM_W          = 9;
  localparam logic [8:0]  VCOM_ZERO       = 9'h000;

  typedef enum logic [1:0] {
    PPCR_DET_IDLE,
    PPCR_DET_KILL,
    PPCR_DET_HOLD
  } ppcr_det_state_t;

endpackage

//--- logic/ppcr_line_pacer.sv
// line counter giving one pulse every N display lines
`timescale 1ns/1ns
module ppcr_line_pacer #(
  parameter int LINES = 8
) (
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic run_i,
  input  wire logic line_start_i,
  output logic      tick_o
);

  localparam int CNT_W = (LINES > 1) ? $clog2(LINES) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(LINES - 1);

  initial begin
    if (LINES < 2) begin
      $error("ppcr_line_pacer: LINES must be at least 2");
    end
  end

  logic [CNT_W-1:0] line_cnt;
  logic [CNT_W-1:0] next_line_cnt;
  wire              wrap = line_start_i && (line_cnt == LAST);

  assign next_line_cnt = !run_i ? '0 :
                         wrap ? '0 :
                         line_start_i ? line_cnt + CNT_W'(1) : line_cnt;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      line_cnt <= '0;
      tick_o   <= 1'b0;
    end else begin
      line_cnt <= next_line_cnt;
      tick_o   <= run_i && wrap;
    end
  end

endmodule

//--- logic/ppcr_regs.sv
// page-4 panel power configuration registers and their control decode
// What this block does
// - bit 4 of the regulator cap register set to 1 selects the two off-chip caps, 0 runs without.
// - that cap select bit sits in register 7A and resets to zero on every kind of reset.
// - sensitivity field 1111 gives high, 1011 medium and 0010 low detection sensitivity.
// - sensitivity field 0000 turns low-voltage and battery-removal detection off.
// - with response bit D7 at 0 a detection kills pump power at once, then requests sleep-in.
// - with response bit at 1 a detection requests the ordinary power-off and sleep-in sequence.
// - with force-zero clear, VCOM follows level a for direction 0 and level b for direction 1.
// - with force-zero set, VCOM is driven to zero volts whatever the direction.
// - the seven-bit clamp code steps 0.18 V per code, only 03h to 41h being valid.
// - the reload enable bit lets gamma settings reload in sleep-out, and stops it when 0.
// - the periodic bit makes the reload repeat once every eight lines in sleep-out.
// - the registers take accesses in normal, idle and sleep-in states alike.
`timescale 1ns/1ns
module ppcr_regs
  import ppcr_pkg::*;
#(
  parameter int RELOAD_PERIOD = RELOAD_LINES
) (
  input  wire logic              sys_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              soft_reset_i,
  input  wire logic              page4_sel_i,
  input  wire logic              cmd_wr_i,
  input  wire logic              cmd_rd_i,
  input  wire logic [ADDR_W-1:0] cmd_addr_i,
  input  wire logic [DATA_W-1:0] cmd_wdata_i,
  output logic      [DATA_W-1:0] cmd_rdata_o,
  output logic                   cmd_rvalid_o,
  input  wire logic              low_voltage_detect_i,
  input  wire logic              panel_scan_direction_i,
  input  wire logic [VCOM_W-1:0] common_level_a_i,
  input  wire logic [VCOM_W-1:0] common_level_b_i,
  input  wire logic              sleep_out_i,
  input  wire logic              line_start_i,
  output logic                   ext_regulator_cap_sel_o,
  output logic                   detect_enable_o,
  output logic      [1:0]        detect_level_o,
  output logic                   detect_code_valid_o,
  output logic                   pump_kill_o,
  output logic                   sleep_in_req_o,
  output logic                   normal_off_req_o,
  output logic      [VCOM_W-1:0] common_level_o,
  output logic                   common_voltage_force_zero_o,
  output logic      [6:0]        neg_gate_clamp_code_o,
  output logic                   clamp_code_valid_o,
  output logic                   tone_curve_reload_o
);

  initial begin
    if (RELOAD_PERIOD < 2) begin
      $error("ppcr_regs: RELOAD_PERIOD must be at least 2");
    end
    if (SENS_MSB - SENS_LSB != 3) begin
      $error("ppcr_regs: sensitivity field must be four bits wide");
    end
    if (CLAMP_MSB != 6 || EXT_CAP_BIT >= DATA_W) begin
      $error("ppcr_regs: clamp or cap field does not fit the register");
    end
    if (RESP_BIT >= DATA_W || VCOM_ZERO_BIT >= DATA_W) begin
      $error("ppcr_regs: control bit beyond the register width");
    end
  end

  // register storage
  logic [DATA_W-1:0] ext_cap_reg;
  logic [DATA_W-1:0] lv_sens_reg;
  logic [DATA_W-1:0] lv_resp_reg;
  logic [DATA_W-1:0] vcom_mode_reg;
  logic [DATA_W-1:0] vgl_clamp_reg;
  logic [DATA_W-1:0] gma_reload_reg;

  // address decode, no power-state gating
  // access in every state
  wire wr_ok        = cmd_wr_i && page4_sel_i;
  wire wr_ext_cap   = wr_ok && (cmd_addr_i == ADDR_EXT_CAP);
  wire wr_lv_sens   = wr_ok && (cmd_addr_i == ADDR_LV_SENS);
  wire wr_lv_resp   = wr_ok && (cmd_addr_i == ADDR_LV_RESP);
  wire wr_vcom_mode = wr_ok && (cmd_addr_i == ADDR_VCOM_MODE);
  wire wr_vgl_clamp = wr_ok && (cmd_addr_i == ADDR_VGL_CLAMP);
  wire wr_gma       = wr_ok && (cmd_addr_i == ADDR_GMA_RELOAD);

  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (cmd_addr_i)
      ADDR_EXT_CAP:    rd_mux = ext_cap_reg;
      ADDR_LV_SENS:    rd_mux = lv_sens_reg;
      ADDR_LV_RESP:    rd_mux = lv_resp_reg;
      ADDR_VCOM_MODE:  rd_mux = vcom_mode_reg;
      ADDR_VGL_CLAMP:  rd_mux = vgl_clamp_reg;
      ADDR_GMA_RELOAD: rd_mux = gma_reload_reg;
      default:         rd_mux = '0;
    endcase
  end
  wire [DATA_W-1:0] next_rdata = page4_sel_i ? rd_mux : '0;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_cap_reg    <= RST_EXT_CAP;
      lv_sens_reg    <= RST_LV_SENS;
      lv_resp_reg    <= RST_LV_RESP;
      vcom_mode_reg  <= RST_VCOM_MODE;
      vgl_clamp_reg  <= RST_VGL_CLAMP;
      gma_reload_reg <= RST_GMA_RELOAD;
    end else if (soft_reset_i) begin
      ext_cap_reg    <= RST_EXT_CAP;
      lv_sens_reg    <= RST_LV_SENS;
      lv_resp_reg    <= RST_LV_RESP;
      vcom_mode_reg  <= RST_VCOM_MODE;
      vgl_clamp_reg  <= RST_VGL_CLAMP;
      gma_reload_reg <= RST_GMA_RELOAD;
    end else begin
      if (wr_ext_cap) begin
        ext_cap_reg <= cmd_wdata_i;
      end
      if (wr_lv_sens) begin
        lv_sens_reg <= cmd_wdata_i;
      end
      if (wr_lv_resp) begin
        lv_resp_reg <= cmd_wdata_i;
      end
      if (wr_vcom_mode) begin
        vcom_mode_reg <= cmd_wdata_i;
      end
      if (wr_vgl_clamp) begin
        vgl_clamp_reg <= cmd_wdata_i;
      end
      if (wr_gma) begin
        gma_reload_reg <= cmd_wdata_i;
      end
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_rdata_o  <= '0;
      cmd_rvalid_o <= 1'b0;
    end else begin
      cmd_rdata_o  <= cmd_rd_i ? next_rdata : cmd_rdata_o;
      cmd_rvalid_o <= cmd_rd_i;
    end
  end

  // field extraction
  wire [3:0] sens_code    = lv_sens_reg[SENS_MSB:SENS_LSB];
  wire       resp_graceful = lv_resp_reg[RESP_BIT];
  wire       vcom_zero     = vcom_mode_reg[VCOM_ZERO_BIT];
  wire [6:0] clamp_code    = vgl_clamp_reg[CLAMP_MSB:0];
  wire       reload_on     = gma_reload_reg[RELOAD_ON_BIT];
  wire       reload_per    = gma_reload_reg[RELOAD_PER_BIT];

  wire sens_high = (sens_code == SENS_HIGH);
  wire sens_med  = (sens_code == SENS_MEDIUM);
  wire sens_low  = (sens_code == SENS_LOW);
  wire sens_valid = sens_high || sens_med || sens_low;
  wire [1:0] next_level = sens_high ? LEVEL_HIGH :
                          sens_med  ? LEVEL_MEDIUM :
                          sens_low  ? LEVEL_LOW : LEVEL_NONE;
  wire det_enabled = (sens_code != SENS_OFF);

  wire [VCOM_W-1:0] dir_level = panel_scan_direction_i ? common_level_b_i
                                                       : common_level_a_i;
  wire [VCOM_W-1:0] next_vcom = vcom_zero ? VCOM_ZERO : dir_level;

  wire clamp_ok = (clamp_code >= CLAMP_MIN) && (clamp_code <= CLAMP_MAX);

  // registered analog controls
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_regulator_cap_sel_o     <= 1'b0;
      detect_enable_o             <= 1'b0;
      detect_level_o              <= LEVEL_NONE;
      detect_code_valid_o         <= 1'b0;
      common_level_o              <= VCOM_ZERO;
      common_voltage_force_zero_o <= 1'b0;
      neg_gate_clamp_code_o       <= '0;
      clamp_code_valid_o          <= 1'b0;
    end else begin
      ext_regulator_cap_sel_o     <= ext_cap_reg[EXT_CAP_BIT];
      detect_enable_o             <= det_enabled;
      detect_level_o              <= next_level;
      detect_code_valid_o         <= sens_valid;
      common_level_o              <= next_vcom;
      common_voltage_force_zero_o <= vcom_zero;
      neg_gate_clamp_code_o       <= clamp_code;
      clamp_code_valid_o          <= clamp_ok;
    end
  end

  // detector comparator is asynchronous
  logic det_sync_a;
  logic det_sync_b;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      det_sync_a <= 1'b0;
      det_sync_b <= 1'b0;
    end else begin
      det_sync_a <= low_voltage_detect_i;
      det_sync_b <= det_sync_a;
    end
  end

  wire det_hit = det_sync_b && det_enabled;

  // detection response sequencer
  ppcr_det_state_t det_state;
  ppcr_det_state_t next_det_state;
  logic            next_kill;
  logic            next_sleep_req;
  logic            next_off_req;

  always_comb begin
    next_det_state = det_state;
    next_kill      = pump_kill_o;
    next_sleep_req = 1'b0;
    next_off_req   = 1'b0;
    case (det_state)
      PPCR_DET_IDLE: begin
        if (det_hit && !resp_graceful) begin
          next_kill      = 1'b1;
          next_det_state = PPCR_DET_KILL;
        end else if (det_hit) begin
          next_off_req   = 1'b1;
          next_det_state = PPCR_DET_HOLD;
        end
      end
      PPCR_DET_KILL: begin
        next_sleep_req = 1'b1;
        next_det_state = PPCR_DET_HOLD;
      end
      PPCR_DET_HOLD: begin
        if (!det_sync_b) begin
          next_kill      = 1'b0;
          next_det_state = PPCR_DET_IDLE;
        end
      end
      default: begin
        next_kill      = 1'b0;
        next_det_state = PPCR_DET_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      det_state        <= PPCR_DET_IDLE;
      pump_kill_o      <= 1'b0;
      sleep_in_req_o   <= 1'b0;
      normal_off_req_o <= 1'b0;
    end else begin
      det_state        <= next_det_state;
      pump_kill_o      <= next_kill;
      sleep_in_req_o   <= next_sleep_req;
      normal_off_req_o <= next_off_req;
    end
  end

  // gamma reload pacing
  logic sleep_out_q;
  logic line_tick;
  wire  reload_run = reload_on && reload_per && sleep_out_i;
  wire  sleep_out_rise = sleep_out_i && !sleep_out_q;

  ppcr_line_pacer #(
    .LINES (RELOAD_PERIOD)
  ) u_pacer (
    .sys_clk_i    (sys_clk_i),
    .sys_rst_i    (sys_rst_i),
    .run_i        (reload_run),
    .line_start_i (line_start_i),
    .tick_o       (line_tick)
  );

  // reload only when enabled in sleep-out
  wire next_reload = reload_on && sleep_out_i &&
                     (reload_per ? line_tick : sleep_out_rise);

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sleep_out_q         <= 1'b0;
      tone_curve_reload_o <= 1'b0;
    end else begin
      sleep_out_q         <= sleep_out_i;
      tone_curve_reload_o <= next_reload;
    end
  end

endmodule

//--- sim/ppcr_host_model.sv
// host-side command driver for the page-4 register bank
`timescale 1ns/1ns
module ppcr_host_model
  import ppcr_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic [DATA_W-1:0] cmd_rdata_i,
  input  wire logic              cmd_rvalid_i,
  output logic                   page4_sel_o,
  output logic                   cmd_wr_o,
  output logic                   cmd_rd_o,
  output logic      [ADDR_W-1:0] cmd_addr_o,
  output logic      [DATA_W-1:0] cmd_wdata_o
);
  initial begin
    page4_sel_o = 1'b1;
    cmd_wr_o    = 1'b0;
    cmd_rd_o    = 1'b0;
    cmd_addr_o  = 8'h00;
    cmd_wdata_o = 8'h00;
  end

  // one command, bus lines scrambled once released
  task automatic xfer(input logic p4, input logic wr, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q, output logic v);
    @(posedge sys_clk_i);
    page4_sel_o <= p4;
    cmd_wr_o    <= wr;
    cmd_rd_o    <= ~wr;
    cmd_addr_o  <= a;
    cmd_wdata_o <= d;
    @(posedge sys_clk_i);
    cmd_wr_o    <= 1'b0;
    cmd_rd_o    <= 1'b0;
    page4_sel_o <= 1'b1;
    cmd_addr_o  <= ~a;
    cmd_wdata_o <= ~d;
    #1;
    q = cmd_rdata_i;
    v = cmd_rvalid_i;
  endtask
endmodule

//--- sim/ppcr_regs_properties.sv
// timing checks on the page-4 register bank ports
`timescale 1ns/1ns
module ppcr_regs_checker
  import ppcr_pkg::*;
(
  input wire logic              sys_clk_i,
  input wire logic              sys_rst_i,
  input wire logic              soft_reset_i,
  input wire logic              page4_sel_i,
  input wire logic              cmd_wr_i,
  input wire logic              cmd_rd_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  input wire logic [DATA_W-1:0] cmd_wdata_i,
  input wire logic              cmd_rvalid_o,
  input wire logic              panel_scan_direction_i,
  input wire logic [VCOM_W-1:0] common_level_a_i,
  input wire logic [VCOM_W-1:0] common_level_b_i,
  input wire logic              sleep_out_i,
  input wire logic              ext_regulator_cap_sel_o,
  input wire logic              detect_enable_o,
  input wire logic [1:0]        detect_level_o,
  input wire logic              pump_kill_o,
  input wire logic              sleep_in_req_o,
  input wire logic              normal_off_req_o,
  input wire logic [VCOM_W-1:0] common_level_o,
  input wire logic              common_voltage_force_zero_o,
  input wire logic [6:0]        neg_gate_clamp_code_o,
  input wire logic              clamp_code_valid_o,
  input wire logic              tone_curve_reload_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic wr_ok = cmd_wr_i && page4_sel_i && !soft_reset_i;

  a_read_answer: assert property (cmd_rd_i |=> cmd_rvalid_o)
    else $error("read without answer");
  a_answer_cause: assert property (cmd_rvalid_o |-> $past(cmd_rd_i))
    else $error("answer without read");
  a_cap_follows: assert property (wr_ok && cmd_addr_i == ADDR_EXT_CAP |=>
    ##1 ext_regulator_cap_sel_o == $past(cmd_wdata_i[EXT_CAP_BIT], 2))
    else $error("cap select not taken from write");
  a_sens_high: assert property (wr_ok && cmd_addr_i == ADDR_LV_SENS &&
    cmd_wdata_i[7:4] == SENS_HIGH |=> ##1 detect_level_o == LEVEL_HIGH)
    else $error("high sensitivity not decoded");
  a_sens_off: assert property (wr_ok && cmd_addr_i == ADDR_LV_SENS &&
    cmd_wdata_i[7:4] == SENS_OFF |=> ##1 !detect_enable_o)
    else $error("detection still enabled");
  a_kill_sleep: assert property ($rose(pump_kill_o) |=>
    sleep_in_req_o ##1 !sleep_in_req_o)
    else $error("kill not followed by one sleep request");
  a_off_alone: assert property (normal_off_req_o |-> !pump_kill_o ##1 !normal_off_req_o)
    else $error("ordinary power-off request malformed");
  a_vcom_select: assert property (!common_voltage_force_zero_o && !$past(sys_rst_i) &&
    !$past(common_voltage_force_zero_o) |-> common_level_o == ($past(panel_scan_direction_i)
    ? $past(common_level_b_i) : $past(common_level_a_i)))
    else $error("vcom level from wrong source");
  a_vcom_zero: assert property (common_voltage_force_zero_o &&
    $past(common_voltage_force_zero_o) |-> common_level_o == VCOM_ZERO)
    else $error("vcom not forced to zero");
  a_clamp_range: assert property (clamp_code_valid_o ==
    (neg_gate_clamp_code_o >= CLAMP_MIN && neg_gate_clamp_code_o <= CLAMP_MAX))
    else $error("clamp validity wrong");
  a_reload_state: assert property (tone_curve_reload_o |-> $past(sleep_out_i)
    ##1 !tone_curve_reload_o)
    else $error("reload outside sleep-out or too long");

  c_kill: cover property ($rose(pump_kill_o));
  c_off: cover property (normal_off_req_o);
  c_reload: cover property (tone_curve_reload_o);
  c_read: cover property (cmd_rvalid_o);
endmodule

bind ppcr_regs ppcr_regs_checker u_ppcr_regs_checker (
  .sys_clk_i, .sys_rst_i, .soft_reset_i, .page4_sel_i, .cmd_wr_i, .cmd_rd_i, .cmd_addr_i,
  .cmd_wdata_i, .cmd_rvalid_o, .panel_scan_direction_i, .common_level_a_i,
  .common_level_b_i, .sleep_out_i, .ext_regulator_cap_sel_o, .detect_enable_o,
  .detect_level_o, .pump_kill_o, .sleep_in_req_o, .normal_off_req_o, .common_level_o,
  .common_voltage_force_zero_o, .neg_gate_clamp_code_o, .clamp_code_valid_o,
  .tone_curve_reload_o
);

//--- sim/tb_ppcr_regs.sv
// self-checking bench for the page-4 power configuration registers
`timescale 1ns/1ns
module tb_ppcr_regs
  import ppcr_pkg::*;
;
  localparam logic [7:0] ADDRS [6] = '{ADDR_EXT_CAP, ADDR_LV_SENS, ADDR_LV_RESP,
                                       ADDR_VCOM_MODE, ADDR_VGL_CLAMP, ADDR_GMA_RELOAD};
  localparam logic [7:0] RSTS [6]  = '{RST_EXT_CAP, RST_LV_SENS, RST_LV_RESP,
                                       RST_VCOM_MODE, RST_VGL_CLAMP, RST_GMA_RELOAD};
  localparam logic [7:0] MASKS [6] = '{8'h10, 8'hF0, 8'h80, 8'h08, 8'h7F, 8'hC0};
  logic sys_clk_i, sys_rst_i, soft_reset_i, page4_sel_i, cmd_wr_i, cmd_rd_i, cmd_rvalid_o;
  logic low_voltage_detect_i, panel_scan_direction_i, sleep_out_i, line_start_i;
  logic ext_regulator_cap_sel_o, detect_enable_o, detect_code_valid_o, pump_kill_o;
  logic sleep_in_req_o, normal_off_req_o, common_voltage_force_zero_o;
  logic clamp_code_valid_o, tone_curve_reload_o, v;
  logic [7:0]        cmd_addr_i, cmd_wdata_i, cmd_rdata_o, d, r;
  logic [VCOM_W-1:0] common_level_a_i, common_level_b_i, common_level_o;
  logic [1:0]        detect_level_o;
  logic [6:0]        neg_gate_clamp_code_o;
  int                n_mismatch, comparisons, n_sleep, n_off, n_reload, i, k;

  ppcr_regs #(.RELOAD_PERIOD(RELOAD_LINES)) u_ppcr_regs (.sys_clk_i, .sys_rst_i,
    .soft_reset_i, .page4_sel_i, .cmd_wr_i, .cmd_rd_i, .cmd_addr_i, .cmd_wdata_i,
    .cmd_rdata_o, .cmd_rvalid_o, .low_voltage_detect_i, .panel_scan_direction_i,
    .common_level_a_i, .common_level_b_i, .sleep_out_i, .line_start_i,
    .ext_regulator_cap_sel_o, .detect_enable_o, .detect_level_o, .detect_code_valid_o,
    .pump_kill_o, .sleep_in_req_o, .normal_off_req_o, .common_level_o,
    .common_voltage_force_zero_o, .neg_gate_clamp_code_o, .clamp_code_valid_o,
    .tone_curve_reload_o);
  ppcr_host_model u_ppcr_host_model (.sys_clk_i, .cmd_rdata_i(cmd_rdata_o),
    .cmd_rvalid_i(cmd_rvalid_o), .page4_sel_o(page4_sel_i), .cmd_wr_o(cmd_wr_i),
    .cmd_rd_o(cmd_rd_i), .cmd_addr_o(cmd_addr_i), .cmd_wdata_o(cmd_wdata_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    n_sleep  += (sleep_in_req_o === 1'b1);
    n_off    += (normal_off_req_o === 1'b1);
    n_reload += (tone_curve_reload_o === 1'b1);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr(input logic p4, input logic [7:0] a, input logic [7:0] x);
    u_ppcr_host_model.xfer(p4, 1'b1, a, x, r, v);
  endtask
  task automatic rd(input logic [7:0] a);
    u_ppcr_host_model.xfer(1'b1, 1'b0, a, 8'h00, r, v);
  endtask
  function automatic logic [7:0] legal(input int n, input logic [7:0] x);
    return (x & MASKS[n]) | (RSTS[n] & ~MASKS[n]);
  endfunction
  function automatic logic [3:0] sens_exp(input logic [3:0] c);
    case (c)
      SENS_HIGH:   return {1'b1, LEVEL_HIGH, 1'b1};
      SENS_MEDIUM: return {1'b1, LEVEL_MEDIUM, 1'b1};
      SENS_LOW:    return {1'b1, LEVEL_LOW, 1'b1};
      SENS_OFF:    return {1'b0, LEVEL_NONE, 1'b0};
      default:     return {1'b1, LEVEL_NONE, 1'b0};
    endcase
  endfunction
  task automatic defaults();
    for (int n = 0; n < 6; n++) begin
      rd(ADDRS[n]);
      check({v, r}, {1'b1, RSTS[n]});
    end
    check(ext_regulator_cap_sel_o, 1'b0);
  endtask
  task automatic lines(input int n);
    repeat (n) begin
      @(posedge sys_clk_i) line_start_i <= 1'b1;
      @(posedge sys_clk_i) line_start_i <= 1'b0;
      tick(2);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    {sys_rst_i, soft_reset_i, low_voltage_detect_i, panel_scan_direction_i} = 4'h8;
    {sleep_out_i, line_start_i, common_level_a_i, common_level_b_i} = '0;
    void'($urandom(32'h377f69be));
    repeat (20) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    tick(2);
    defaults();
    check({detect_enable_o, detect_level_o, detect_code_valid_o}, sens_exp(4'hB));
    for (i = 0; i < 24; i++) begin
      k = $urandom_range(5);
      k = (k == 1) ? 0 : k;
      @(posedge sys_clk_i) sleep_out_i <= 1'($urandom);
      d = legal(k, 8'($urandom));
      if (k == 4) d[6:0] = CLAMP_MIN + 7'($urandom_range(62));
      wr(1'b1, ADDRS[k], d);
      rd(ADDRS[k]);
      check({v, r}, {1'b1, d});
      if (k == 0) check(ext_regulator_cap_sel_o, d[EXT_CAP_BIT]);
      if (k == 4) check({clamp_code_valid_o, neg_gate_clamp_code_o}, {1'b1, d[6:0]});
    end
    for (i = 0; i < 16; i++) begin
      wr(1'b1, ADDR_LV_SENS, {i[3:0], 4'hA});
      tick(2);
      check({detect_enable_o, detect_level_o, detect_code_valid_o},
            sens_exp(i[3:0]));
    end
    foreach (MASKS[n]) begin
      d = 8'(n == 0 ? 8'h02 : n == 1 ? 8'h03 : n == 2 ? 8'h41 : 8'h42 + n);
      wr(1'b1, ADDR_VGL_CLAMP, d);
      tick(2);
      check(clamp_code_valid_o, 1'(n == 1 || n == 2));
    end
    wr(1'b0, ADDR_LV_SENS, 8'h0A);
    wr(1'b1, 8'h90, 8'h55);
    rd(8'h90);
    check({v, r}, 9'h100);
    rd(ADDR_LV_SENS);
    check(r, 8'hFA);
    for (i = 0; i < 4; i++) begin
      @(posedge sys_clk_i) panel_scan_direction_i <= i[0];
      common_level_a_i <= 9'($urandom);
      common_level_b_i <= 9'($urandom);
      wr(1'b1, ADDR_VCOM_MODE, legal(3, {4'h0, i[1], 3'h0}));
      tick(3);
      check({common_voltage_force_zero_o, common_level_o}, {i[1], i[1] ? VCOM_ZERO
            : i[0] ? common_level_b_i : common_level_a_i});
    end
    for (i = 0; i < 3; i++) begin
      wr(1'b1, ADDR_LV_SENS, i == 2 ? 8'h0A : 8'hFA);
      wr(1'b1, ADDR_LV_RESP, {i[0], 7'h0B});
      {n_sleep, n_off} = '0;
      @(posedge sys_clk_i) low_voltage_detect_i <= 1'b1;
      tick(8);
      check({pump_kill_o, n_sleep[1:0], n_off[1:0]},
            i == 2 ? 5'h00 : i == 1 ? 5'h01 : 5'h14);
      @(posedge sys_clk_i) low_voltage_detect_i <= 1'b0;
      tick(6);
      check(pump_kill_o, 1'b0);
    end
    for (i = 0; i < 3; i++) begin
      @(posedge sys_clk_i) sleep_out_i <= 1'b0;
      wr(1'b1, ADDR_GMA_RELOAD, legal(5, {i[1] | i[0], i[1], 6'h00}));
      n_reload = 0;
      @(posedge sys_clk_i) sleep_out_i <= 1'b1;
      lines(2 * RELOAD_LINES);
      tick(3);
      check(n_reload, i == 0 ? 0 : i == 1 ? 1 : 2);
    end
    @(posedge sys_clk_i) soft_reset_i <= 1'b1;
    @(posedge sys_clk_i) soft_reset_i <= 1'b0;
    tick(2);
    defaults();
    wr(1'b1, ADDR_EXT_CAP, 8'h10);
    @(posedge sys_clk_i) sys_rst_i <= 1'b1;
    @(posedge sys_clk_i) sys_rst_i <= 1'b0;
    tick(2);
    defaults();
    summarize();
  end

  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
endmodule
